/* File: design/port_a_block.sv */
// Port A pin logic with peripheral open-drain control, APB register slave.
// Assumes synchronous pin inputs, one clock, board resolves pad wires.
//
// Behaviour
// - Control 1: SPI1, capture 2, 1, SPI2 enables
// - Control 1 bits 4..1 read zero
// - Control 2: one enable per capture unit 3..10
// - Reduced parts lack capture 10, 9 enables
// - Control 3: serial 2, 1 enables; 5..1 zero
// - Control 3 bit 0 connects pulse-delay pin
// - Analog pin disables its digital input
// - Eight-bit port with direction and latch
// - Analog bits pick pins 0-3, 5; direction stays
// - Reset: analog pins read zero, pin 4 digital
// - External oscillator takes pins 6, 7
// - Internal oscillator frees pins 6, 7
// - Segment enable takes pins 1, 4, 5
// - Pin 4 feeds timer 0 clock
// - Pin 5 feeds timer 1 clock, timer 3 gate
// - Port read gives pins, write sets latch
// - Direction one releases driver, zero drives latch
// - Latch read returns latched value, pins 6, 7 zero with external oscillator
`include "port_a_map.svh"
`default_nettype none
module port_a_block
   import port_a_pkg::*;
#(
   parameter bit REDUCED_MEMORY = 1'b0  // Family member without capture 9, 10
)
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     ce,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [7:0]               pin_in,
   output logic      [7:0]               pin_o,
   output logic      [7:0]               pin_oe,
   input  wire logic                     osc_external_mode,
   input  wire logic [7:0]               segment_enable_reg_1,
   input  wire logic [7:0]               segment_enable_reg_2,
   input  wire logic [`NUM_OD_LINES-1:0] periph_out,
   input  wire logic [`NUM_OD_LINES-1:0] periph_drive,
   output logic      [`NUM_OD_LINES-1:0] periph_pad_o,
   output logic      [`NUM_OD_LINES-1:0] periph_pad_oe,
   input  wire logic                     pulse_delay_pin,
   output logic                          pulse_delay_input,
   output logic                          timer0_ext_clock_in,
   output logic                          timer1_ext_clock_in,
   output logic                          timer3_gate_in
);

   localparam logic [7:0] OD2_KEEP = REDUCED_MEMORY ? `OD2_REDUCED_MASK : `OD2_MASK;

   // Reset image of all state
   localparam port_state_t RST = '{
      phase:         PH_IDLE,
      prdata:        32'h0000_0000,
      pready:        1'b0,
      pslverr:       1'b0,
      latch:         `RST_LATCH,
      dir:           `RST_DIRECTION,
      analog_bits:   `RST_ANALOG,
      od1:           `RST_OD,
      od2:           `RST_OD,
      od3:           `RST_OD,
      osc_ext:       1'b0,
      osc_caught:    1'b0,
      t0:            1'b0,
      t1:            1'b0,
      t3g:           1'b0,
      pdly:          1'b0,
      analog_wr:     1'b0
   };

   port_state_t r;          // Registered state
   port_state_t n;          // Next state
   logic [7:0]  osc_mask;   // Pins held by the oscillator
   logic [7:0]  seg_mask;   // Pins held by segment drivers
   logic [7:0]  ana_mask;   // Pins in analog mode
   logic [7:0]  pin_read;   // Digital input levels seen by software
   logic [7:0]  dir_read;   // Direction as read back
   logic [7:0]  latch_read; // Latch as read back
   logic [`NUM_OD_LINES-1:0] od_vec;  // Open-drain enable per peripheral line
   logic        wr_hit;     // Write completes at this edge

   pad_if #(.W(8))             pin_bus ();
   pad_if #(.W(`NUM_OD_LINES)) per_bus ();

   // Pin ownership masks
   always_comb
   begin
      // External modes take pins 6 and 7; internal modes free them
      osc_mask = r.osc_ext ? `OSC_PIN_MASK : 8'h00;
      // Segment drivers take pins 1, 4 and 5
      seg_mask    = 8'h00;
      seg_mask[1] = segment_enable_reg_2[`SEG_PIN1_BIT];
      seg_mask[4] = segment_enable_reg_1[`SEG_PIN4_BIT];
      seg_mask[5] = segment_enable_reg_1[`SEG_PIN5_BIT];
      // Analog bits 3:0 to pins 3:0, bit 4 to pin 5
      ana_mask   = {2'b00, r.analog_bits[4], 1'b0, r.analog_bits[3:0]};
      // Analog pins lose the digital input, so they read zero
      pin_read   = pin_in & ~ana_mask & ~seg_mask & ~osc_mask;
      dir_read   = r.dir & ~osc_mask;
      latch_read = r.latch & ~osc_mask;
   end

   // Peripheral line order: SPI1, capture 1, capture 2, SPI2, capture 3..10, serial 1, 2
   assign od_vec = {r.od3[7], r.od3[6], r.od2, r.od1[0], r.od1[6], r.od1[5], r.od1[7]};

   assign wr_hit = (r.phase == PH_ANSWER) && psel && penable && pwrite && !r.pslverr;

   // Next state: bus answer, register writes, input taps
   always_comb
   begin
      n = r;
      unique case (r.phase)
         PH_IDLE:
         begin
            n.pready  = 1'b0;
            // Access phase seen: prepare the answer one cycle later
            if (psel && penable)
            begin
               n.phase   = PH_ANSWER;
               n.pready  = 1'b1;
               n.pslverr = 1'b0;
               n.prdata  = 32'h0000_0000;
               case (paddr)
                  `OFF_PIN_LEVELS:    n.prdata[7:0] = pin_read;
                  `OFF_OUTPUT_LATCH:  n.prdata[7:0] = latch_read;
                  `OFF_DIRECTION:     n.prdata[7:0] = dir_read;
                  `OFF_ANALOG_SELECT: n.prdata[4:0] = r.analog_bits;
                  `OFF_OD_CTRL_1:     n.prdata[7:0] = r.od1;
                  `OFF_OD_CTRL_2:     n.prdata[7:0] = r.od2;
                  `OFF_OD_CTRL_3:     n.prdata[7:0] = r.od3;
                  // Unmapped address answers with an error
                  default:            n.pslverr = 1'b1;
               endcase
            end
         end
         PH_ANSWER:
         begin
            // Transfer ends here; the next may start with its setup cycle
            n.phase   = PH_IDLE;
            n.pready  = 1'b0;
            n.pslverr = 1'b0;
         end
      endcase

      // Register writes at the completing edge only
      if (wr_hit)
      begin
         case (paddr)
            // A port write lands in the latch, never on the pins directly
            `OFF_PIN_LEVELS:    n.latch = pwdata[7:0];
            `OFF_OUTPUT_LATCH:  n.latch = pwdata[7:0];
            `OFF_DIRECTION:     n.dir = pwdata[7:0];
            `OFF_ANALOG_SELECT:
            begin
               n.analog_bits = pwdata[4:0];
               n.analog_wr   = 1'b1;
            end
            `OFF_OD_CTRL_1:     n.od1 = pwdata[7:0] & `OD1_MASK;
            `OFF_OD_CTRL_2:     n.od2 = pwdata[7:0] & OD2_KEEP;
            `OFF_OD_CTRL_3:     n.od3 = pwdata[7:0] & `OD3_MASK;
            default:            n.od3 = r.od3;
         endcase
      end

      // Oscillator mode caught once, on the first enabled edge after reset
      if (!r.osc_caught)
      begin
         n.osc_ext    = osc_external_mode;
         n.osc_caught = 1'b1;
      end

      // Timer inputs run beside the port function
      n.t0   = pin_in[4] & ~seg_mask[4];
      n.t1   = pin_in[5] & ~seg_mask[5] & ~ana_mask[5];
      n.t3g  = pin_in[5] & ~seg_mask[5] & ~ana_mask[5];
      // Pulse-delay input cut off from its pin unless enabled
      n.pdly = pulse_delay_pin & r.od3[`OD3_PULSE_BIT];
   end

   // State register, frozen while ce is low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= RST;
      end
      else if (ce)
      begin
         r <= n;
      end
   end

   // Pin drivers: direction still rules analog pins, so software must hold them as inputs
   assign pin_bus.data  = r.latch;
   assign pin_bus.drive = ~r.dir & ~osc_mask & ~seg_mask;
   assign pin_bus.od    = 8'h00;
   // Peripheral drivers with their open-drain option
   assign per_bus.data  = periph_out;
   assign per_bus.drive = periph_drive;
   assign per_bus.od    = od_vec;

   pad_stage #(.W(8)) u_pin_stage (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pads    (pin_bus.stage)
   );

   pad_stage #(.W(`NUM_OD_LINES)) u_per_stage (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pads    (per_bus.stage)
   );

   // Outputs straight from flip-flops
   assign prdata              = r.prdata;
   assign pready              = r.pready;
   assign pslverr             = r.pslverr;
   assign pin_o               = pin_bus.pad_o;
   assign pin_oe              = pin_bus.pad_oe;
   assign periph_pad_o        = per_bus.pad_o;
   assign periph_pad_oe       = per_bus.pad_oe;
   assign pulse_delay_input   = r.pdly;
   assign timer0_ext_clock_in = r.t0;
   assign timer1_ext_clock_in = r.t1;
   assign timer3_gate_in      = r.t3g;

   // Completing write and read request at a given address
   sequence s_write(logic [7:0] a);
      ce && wr_hit && paddr == a;
   endsequence

   sequence s_read_req(logic [7:0] a);
      ce && r.phase == PH_IDLE && psel && penable && !pwrite && paddr == a;
   endsequence

   property p_od1_write;
      @(posedge pclk) disable iff (!presetn)
      s_write(`OFF_OD_CTRL_1) |=> r.od1 == ($past(pwdata[7:0]) & `OD1_MASK);
   endproperty
   a_od1_write: assert property (p_od1_write) else $error("control 1 write wrong");

   property p_od1_read;
      @(posedge pclk) disable iff (!presetn)
      s_read_req(`OFF_OD_CTRL_1) ##1 pready |-> prdata[4:1] == 4'h0;
   endproperty
   a_od1_read: assert property (p_od1_read) else $error("control 1 reserved bits set");

   property p_od2_write;
      @(posedge pclk) disable iff (!presetn)
      s_write(`OFF_OD_CTRL_2) |=> r.od2 == ($past(pwdata[7:0]) & OD2_KEEP);
   endproperty
   a_od2_write: assert property (p_od2_write) else $error("control 2 write wrong");

   property p_od2_reduced;
      @(posedge pclk) disable iff (!presetn)
      REDUCED_MEMORY |-> r.od2[7:6] == 2'b00;
   endproperty
   a_od2_reduced: assert property (p_od2_reduced) else $error("absent enables set");

   property p_od3_read;
      @(posedge pclk) disable iff (!presetn)
      s_read_req(`OFF_OD_CTRL_3) ##1 pready |-> prdata[5:1] == 5'h00;
   endproperty
   a_od3_read: assert property (p_od3_read) else $error("control 3 reserved bits set");

   property p_pulse_delay;
      @(posedge pclk) disable iff (!presetn)
      ce |=> pulse_delay_input == ($past(pulse_delay_pin) & $past(r.od3[0]));
   endproperty
   a_pulse_delay: assert property (p_pulse_delay) else $error("pulse-delay gating wrong");

   property p_analog_read;
      @(posedge pclk) disable iff (!presetn)
      (s_read_req(`OFF_PIN_LEVELS) and r.analog_bits[0]) |=> prdata[0] == 1'b0;
   endproperty
   a_analog_read: assert property (p_analog_read) else $error("analog pin read non-zero");

   property p_reset_analog;
      @(posedge pclk) disable iff (!presetn)
      !r.analog_wr |-> r.analog_bits == `RST_ANALOG;
   endproperty
   a_reset_analog: assert property (p_reset_analog) else $error("analog reset lost");

   property p_osc_read;
      @(posedge pclk) disable iff (!presetn)
      (s_read_req(`OFF_DIRECTION) and r.osc_ext) |=> prdata[7:6] == 2'b00;
   endproperty
   a_osc_read: assert property (p_osc_read) else $error("oscillator pins read non-zero");

   property p_latch_write;
      @(posedge pclk) disable iff (!presetn)
      s_write(`OFF_PIN_LEVELS) |=> r.latch == $past(pwdata[7:0]) ##1 (!ce || !pready);
   endproperty
   a_latch_write: assert property (p_latch_write) else $error("port write missed latch");

   property p_timer0;
      @(posedge pclk) disable iff (!presetn)
      ce |=> timer0_ext_clock_in == ($past(pin_in[4]) & ~$past(segment_enable_reg_1[6]));
   endproperty
   a_timer0: assert property (p_timer0) else $error("timer 0 tap wrong");

endmodule
`default_nettype wire

/* File: design/port_a_map.svh */
// Register offsets, field positions, masks and reset values of the port A block.
// Assumes byte addressing on a 32-bit APB, one aligned word per register.
`ifndef PORT_A_MAP_SVH
`define PORT_A_MAP_SVH

// Register byte offsets
`define OFF_PIN_LEVELS    8'h00
`define OFF_OUTPUT_LATCH  8'h04
`define OFF_DIRECTION     8'h08
`define OFF_ANALOG_SELECT 8'h0C
`define OFF_OD_CTRL_1     8'h10
`define OFF_OD_CTRL_2     8'h14
`define OFF_OD_CTRL_3     8'h18

// Implemented bits of the open-drain registers
`define OD1_MASK          8'hE1
`define OD2_MASK          8'hFF
`define OD2_REDUCED_MASK  8'h3F
`define OD3_MASK          8'hC1
`define OD3_PULSE_BIT     0

// Pins lost to the oscillator in external modes
`define OSC_PIN_MASK      8'hC0

// Segment enable bit positions for pins 1, 4 and 5
`define SEG_PIN1_BIT      2
`define SEG_PIN4_BIT      6
`define SEG_PIN5_BIT      7

// Reset values
`define RST_LATCH         8'h00
`define RST_DIRECTION     8'hFF
`define RST_ANALOG        5'h1F
`define RST_OD            8'h00

// Number of peripheral lines with an open-drain option
`define NUM_OD_LINES      14

`endif

/* File: design/port_a_pkg.sv */
// Types shared by the port A block.
// Assumes port_a_map.svh supplies the numeric constants.
`default_nettype none
package port_a_pkg;

   // Bus answer phase, one-hot
   typedef enum logic [1:0] {
      PH_IDLE   = 2'b01,
      PH_ANSWER = 2'b10
   } apb_phase_t;

   // All state of the port block
   typedef struct packed {
      apb_phase_t  phase;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [7:0]  latch;
      logic [7:0]  dir;
      logic [4:0]  analog_bits;
      logic [7:0]  od1;
      logic [7:0]  od2;
      logic [7:0]  od3;
      logic        osc_ext;
      logic        osc_caught;
      logic        t0;
      logic        t1;
      logic        t3g;
      logic        pdly;
      logic        analog_wr;
   } port_state_t;

endpackage
`default_nettype wire

/* File: design/pad_if.sv */
// Bundle between the port logic and a registered pad output stage.
// Assumes one controller and one stage per instance.
`default_nettype none
interface pad_if #(parameter int W = 8);
   logic [W-1:0] data;    // Value to put out
   logic [W-1:0] drive;   // Output wanted
   logic [W-1:0] od;      // Open-drain option
   logic [W-1:0] pad_o;   // Registered pad level
   logic [W-1:0] pad_oe;  // Registered pad enable

   modport ctrl  (output data, drive, od, input pad_o, pad_oe);
   modport stage (input data, drive, od, output pad_o, pad_oe);
endinterface
`default_nettype wire

/* File: design/pad_stage.sv */
// Registered pad output stage with push-pull or open-drain drive per bit.
// Assumes the board pulls open-drain lines high and resolves the wire.
`default_nettype none
module pad_stage
   import port_a_pkg::*;
#(
   parameter int W = 8
)
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   pad_if.stage      pads
);

   // Stage state
   typedef struct packed {
      logic [W-1:0] o;
      logic [W-1:0] oe;
   } stage_state_t;

   stage_state_t s_reg;
   stage_state_t s_next;
   logic [W-1:0] o_bit;   // Per-bit next level
   logic [W-1:0] oe_bit;  // Per-bit next enable

   // One output cell per bit
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_cell
         // Open drain pulls low for zero, releases for one
         assign o_bit[i]  = pads.od[i] ? 1'b0 : pads.data[i];
         assign oe_bit[i] = pads.drive[i] & (~pads.od[i] | ~pads.data[i]);
      end
   endgenerate

   // Next state
   always_comb
   begin
      s_next    = s_reg;
      s_next.o  = o_bit;
      s_next.oe = oe_bit;
   end

   // Register, frozen while ce is low; pads released in reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   assign pads.pad_o  = s_reg.o;
   assign pads.pad_oe = s_reg.oe;

   property p_push_pull;
      @(posedge pclk) disable iff (!presetn)
      (ce && pads.drive[0] && !pads.od[0]) |=> (pads.pad_oe[0] && pads.pad_o[0] == $past(pads.data[0]));
   endproperty
   a_push_pull: assert property (p_push_pull) else $error("push-pull bit not driven");

   property p_no_drive;
      @(posedge pclk) disable iff (!presetn)
      (ce && !pads.drive[0]) |=> !pads.pad_oe[0];
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("undriven bit still enabled");

   property p_od_release;
      @(posedge pclk) disable iff (!presetn)
      (ce && pads.od[0] && pads.data[0]) |=> !pads.pad_oe[0];
   endproperty
   a_od_release: assert property (p_od_release) else $error("open-drain one not released");

   property p_od_low;
      @(posedge pclk) disable iff (!presetn)
      (ce && pads.od[0] && pads.drive[0] && !pads.data[0]) |=> (pads.pad_oe[0] && !pads.pad_o[0]);
   endproperty
   a_od_low: assert property (p_od_low) else $error("open-drain zero not pulled low");

endmodule
`default_nettype wire

/* File: bench/port_board_model.sv */
// Board circuitry on the port A pads and on the peripheral open-drain lines.
// Assumes registered pad outputs and a bench that drives the board's own sources.
`default_nettype none
module port_board_model
#(
   parameter int NL = 14  // Peripheral lines with an open-drain option
)
(
   input  wire logic [7:0]    pin_o,
   input  wire logic [7:0]    pin_oe,
   input  wire logic [7:0]    ext_src,
   input  wire logic [NL-1:0] line_o,
   input  wire logic [NL-1:0] line_oe,
   output logic      [7:0]    pin_lvl,
   output logic      [NL-1:0] line_lvl
);
   timeunit 1ns;
   timeprecision 1ns;

   // Released pads show the board source, which the bench changes often,
   // so a stale driven level can never pass for a good one
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_src);

   // Pull-up resistor lifts every released line to the high level
   assign line_lvl = (line_oe & line_o) | ~line_oe;
endmodule
`default_nettype wire

/* File: bench/test_port_a_open_drain_control.sv */
// Self-checking bench of the port A block against an integer model.
// Assumes one-wait-cycle APB answers and the board model on the pads.
`default_nettype none
`define CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("[ERR] %0t got %h want %h", $time, g, e); \
      end \
   end

module test_port_a_open_drain_control
   import port_a_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        pclk, presetn, ce, psel, penable, pwrite;  // Clock, reset, bus controls
   logic        pready, pslverr, osc_ext, pulse_pin;       // Answers, straps
   logic        pulse_in, tmr0, tmr1, tmr3g;               // Peripheral taps
   logic [7:0]  paddr, pin_in, pin_o, pin_oe;              // Address, pads
   logic [7:0]  ext_src, seg1, seg2;                       // Board source, segments
   logic [31:0] pwdata, prdata, prdata_red;                // Bus data
   logic [31:0] rd_v, red_v;                               // Last read data
   logic        err_v;                                     // Last error flag
   logic [13:0] p_out, p_drv, p_pad_o, p_pad_oe, p_lvl;    // Peripheral lines
   int          fail_count, comparisons, seed;             // Bookkeeping
   int          m_latch, m_dir, m_an, m_od1, m_od2, m_od3; // Register model
   int          m_ext;                                     // Oscillator mode model

   port_a_block #(.REDUCED_MEMORY(1'b0)) u_dut
   (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_o(pin_o),
      .pin_oe(pin_oe), .osc_external_mode(osc_ext), .segment_enable_reg_1(seg1),
      .segment_enable_reg_2(seg2), .periph_out(p_out), .periph_drive(p_drv),
      .periph_pad_o(p_pad_o), .periph_pad_oe(p_pad_oe), .pulse_delay_pin(pulse_pin),
      .pulse_delay_input(pulse_in), .timer0_ext_clock_in(tmr0),
      .timer1_ext_clock_in(tmr1), .timer3_gate_in(tmr3g)
   );

   // Smaller family member on the same bus, read back in parallel
   port_a_block #(.REDUCED_MEMORY(1'b1)) u_dut_reduced
   (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_red),
      .pready(), .pslverr(), .pin_in(pin_in), .pin_o(), .pin_oe(),
      .osc_external_mode(osc_ext), .segment_enable_reg_1(seg1),
      .segment_enable_reg_2(seg2), .periph_out(p_out), .periph_drive(p_drv),
      .periph_pad_o(), .periph_pad_oe(), .pulse_delay_pin(pulse_pin),
      .pulse_delay_input(), .timer0_ext_clock_in(), .timer1_ext_clock_in(),
      .timer3_gate_in()
   );

   port_board_model #(.NL(14)) u_board
   (
      .pin_o(pin_o), .pin_oe(pin_oe), .ext_src(ext_src), .line_o(p_pad_o),
      .line_oe(p_pad_oe), .pin_lvl(pin_in), .line_lvl(p_lvl)
   );

   // Free-running bus clock, 8 ns period
   always #4 pclk = ~pclk;

   // Pins taken from the port by oscillator or segments
   function automatic logic [7:0] drv_mask();
      return {m_ext ? 2'b11 : 2'b00, seg1[7], seg1[6], 2'b00, seg2[2], 1'b0};
   endfunction

   // Expected pad levels from the model, never from the design
   function automatic logic [7:0] pexp();
      logic [7:0] eoe;
      eoe = ~m_dir[7:0] & ~drv_mask();
      return (eoe & m_latch[7:0]) | (~eoe & ext_src);
   endfunction

   // Open-drain enable of peripheral line i
   function automatic logic od_of(int i);
      logic [13:0] v;
      v = {m_od3[7], m_od3[6], m_od2[7:0], m_od1[0], m_od1[6], m_od1[5], m_od1[7]};
      return v[i];
   endfunction

   // Expected read data; unmapped places read zero
   function automatic logic [31:0] exp_rd(logic [7:0] a);
      logic [7:0] osc;
      osc = m_ext ? 8'hC0 : 8'h00;
      case (a)
         8'h00: return 32'(pexp() & ~(drv_mask() | {2'b00, m_an[4], 1'b0, m_an[3:0]}));
         8'h04: return 32'(m_latch[7:0] & ~osc);
         8'h08: return 32'(m_dir[7:0] & ~osc);
         8'h0C: return 32'(m_an[4:0]);
         8'h10: return 32'(m_od1[7:0]);
         8'h14: return 32'(m_od2[7:0]);
         8'h18: return 32'(m_od3[7:0]);
         default: return 32'h0000_0000;
      endcase
   endfunction

   task automatic print_verdict();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         fail_count++;
         print_verdict();
      end
      rd_v    = prdata;
      red_v   = prdata_red;
      err_v   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Write and update the model with the implemented bits only
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      case (a)
         8'h00, 8'h04: m_latch = d[7:0];
         8'h08: m_dir = d[7:0];
         8'h0C: m_an = d[4:0];
         8'h10: m_od1 = d[7:0] & 8'hE1;
         8'h14: m_od2 = d[7:0];
         8'h18: m_od3 = d[7:0] & 8'hC1;
         default: ;
      endcase
   endtask

   // Read every place, the unmapped one included
   task automatic rd_all();
      for (int a = 0; a <= 28; a += 4)
      begin
         apb(1'b0, 8'(a), 32'h0000_0000);
         `CHK(rd_v, exp_rd(8'(a)))
         `CHK(err_v, (a > 24))
         if (a == 20)
            `CHK(red_v, exp_rd(8'h14) & 32'h0000_003F)
      end
   endtask

   // Pads, taps and peripheral lines after their one-edge lag
   task automatic chk_pins();
      logic [7:0] eoe;
      logic [7:0] pe;
      repeat (3) @(posedge pclk);
      eoe = ~m_dir[7:0] & ~drv_mask();
      pe = pexp();
      `CHK(pin_oe, eoe)
      `CHK(pin_o & eoe, m_latch[7:0] & eoe)
      `CHK(tmr0, pe[4] & ~seg1[6])
      `CHK(tmr1, pe[5] & ~seg1[7] & ~m_an[4])
      `CHK(tmr3g, pe[5] & ~seg1[7] & ~m_an[4])
      `CHK(pulse_in, pulse_pin & m_od3[0])
      for (int i = 0; i < 14; i++)
      begin
         `CHK(p_pad_oe[i], od_of(i) ? p_drv[i] & ~p_out[i] : p_drv[i])
         `CHK(p_lvl[i], ~p_drv[i] | p_out[i])
         `CHK(p_pad_o[i], od_of(i) ? 1'b0 : p_out[i])
      end
   endtask

   // Reset with a chosen oscillator mode, then check reset values
   task automatic do_reset(input logic ext);
      presetn <= 1'b0;
      osc_ext <= ext;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      m_latch = 0;
      m_dir   = 8'hFF;
      m_an    = 5'h1F;
      m_od1   = 0;
      m_od2   = 0;
      m_od3   = 0;
      m_ext   = ext;
      repeat (2) @(posedge pclk);
      rd_all();
      chk_pins();
   endtask

   // Random board, segments and registers, then a full check
   task automatic shake();
      logic [31:0] v;
      v = $random(seed);
      ext_src   <= 8'($random(seed));
      seg1      <= v[7:0];
      seg2      <= v[15:8];
      p_out     <= 14'($random(seed));
      p_drv     <= 14'($random(seed));
      pulse_pin <= v[16];
      wr(v[17] ? 8'h00 : 8'h04, $random(seed));
      wr(8'h0C, 32'(v[22:18]));
      // Analog pins kept as inputs by software
      wr(8'h08, $random(seed) | {m_an[4], 1'b0, m_an[3:0]});
      wr(8'h10, $random(seed));
      wr(8'h14, $random(seed));
      wr(8'h18, $random(seed));
      wr(8'h1C, $random(seed));
      rd_all();
      chk_pins();
   endtask

   // Main sequence: internal oscillator first, then external
   initial
   begin
      seed        = 5588;
      fail_count  = 0;
      comparisons = 0;
      pclk        = 1'b0;
      presetn     = 1'b0;
      ce          = 1'b1;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 8'h00;
      pwdata      = 32'h0000_0000;
      osc_ext     = 1'b0;
      pulse_pin   = 1'b0;
      ext_src     = 8'hFF;
      seg1        = 8'h00;
      seg2        = 8'h00;
      p_out       = 14'h0000;
      p_drv       = 14'h0000;
      do_reset(1'b0);
      repeat (12) shake();
      do_reset(1'b1);
      repeat (8) shake();
      print_verdict();
   end
endmodule
`default_nettype wire
